// >>> psg_pkg.sv
// Shared constants, encodings and state layout of the PWM sync and power-good block
package psg_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ       = 100;
    localparam int OK_DELAY_NS   = 20000;
    localparam int OK_CYC        = OK_DELAY_NS * CLK_MHZ / 1000;
    localparam int TRANS_NS      = 20000;
    localparam int TRANS_CYC     = TRANS_NS * CLK_MHZ / 1000;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int          AW          = 8;
    localparam int          DW          = 32;
    localparam logic [7:0]  ADDR_PERIOD = 8'h00;
    localparam logic [7:0]  ADDR_DUTY   = 8'h04;
    localparam logic [7:0]  ADDR_STATUS = 8'h08;
    localparam logic [7:0]  ADDR_MASK   = 8'h0C;
    localparam logic [7:0]  ADDR_STATE  = 8'h10;
    localparam logic [15:0] PERIOD_RST  = 16'h014D;
    localparam logic [15:0] DUTY_RST    = 16'h00A6;

    // Event bits of status and mask
    localparam int NEV       = 4;
    localparam int EV_OK_UP  = 0;
    localparam int EV_OK_DN  = 1;
    localparam int EV_LOST   = 2;
    localparam int EV_LOCK   = 3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ROLE_MASTER = 2'b00,
        ROLE_SLV180 = 2'b01,
        ROLE_SLV0   = 2'b10
    } psg_role_t;

    typedef enum logic [1:0] {
        LK_FREE    = 2'b00,
        LK_LOCKED  = 2'b01,
        LK_TRANSIT = 2'b10
    } psg_lock_t;

    typedef struct packed {
        psg_role_t        role;
        psg_lock_t        lock;
        logic [15:0]      cnt;
        logic [15:0]      wdog;
        logic [15:0]      tcnt;
        logic [15:0]      pg_cnt;
        logic             link_prev;
        logic             hs;
        logic             ph_o;
        logic             ph_oe;
        logic             ok_oe;
        logic             ok_lvl;
        logic [15:0]      per;
        logic [15:0]      duty;
        logic [NEV-1:0]   sts;
        logic [NEV-1:0]   msk;
        logic [DW-1:0]    rdata;
        logic             irq;
    } psg_state_t;

endpackage

// >>> psg_sync.sv
// Two-flop synchroniser bank for asynchronous pin levels
`timescale 1ns/10ps
module psg_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_sys, // System clock
    input  wire logic         rst_b,   // Async reset, active low
    input  wire logic [W-1:0] d,       // Asynchronous levels
    output logic      [W-1:0] q        // Synchronised levels
);

    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
                meta_q[i] <= 1'b0;
                q[i]      <= 1'b0;
            end else begin
                meta_q[i] <= d[i];
                q[i]      <= meta_q[i];
            end
        end
    end

endmodule

// >>> psg_top.sv
// PWM timebase with master/slave synchronisation and power-good supervision
//
// Overview of operation
// R1 - The ok flag pin is open-drain and is pulled low while any out-of-regulation condition holds.
// R2 - The flag is held low while the feedback voltage is outside the good window.
// R3 - The flag is held low while soft-start runs, i.e. the ramp is below its done level.
// R4 - The flag is held low while undervoltage lockout is asserted.
// R5 - The flag is held low while an overcurrent or short-circuit fault is detected.
// R6 - The flag is held low while an overtemperature fault is detected.
// R7 - Once all blocking conditions clear, the flag is released after the 20 us delay.
// R8 - With the role pin tied to supply the block is master and drives the switching-rate clock.
// R9 - In master role the driven clock has a 50% duty cycle.
// R10 - In master role each falling edge of the driven clock meets a rising high-side drive edge.
// R11 - With the role pin grounded, each high-side pulse starts on the input clock rising edge.
// R12 - With the role pin open, each high-side pulse starts on the input clock falling edge.
// R13 - The external clock must stay within 30 percent of the programmed free-running rate.
// R14 - On loss of the external clock the block runs at 0.7 times the free rate for 20 us.
// R15 - After that interval the block returns to its programmed free-running rate.
// R16 - Slave roles are advised whenever master operation is not required.
// R17 - The clock is lost after about one and a half free periods without an edge; edges relock.
`timescale 1ns/10ps
module psg_top (
    input  wire logic                   clk_sys,          // System clock, 100 MHz
    input  wire logic                   rst_b,            // Async reset, active low
    input  wire logic                   fb_in_window,     // Feedback inside good window
    input  wire logic                   ramp_done,        // Soft-start ramp above done level
    input  wire logic                   uvlo_active,      // Undervoltage lockout
    input  wire logic                   ocp_fault,        // Overcurrent fault
    input  wire logic                   scp_fault,        // Short-circuit fault
    input  wire logic                   otp_fault,        // Overtemperature fault
    input  wire logic                   role_at_supply,   // Role pin tied to supply
    input  wire logic                   role_at_ground,   // Role pin tied to ground
    input  wire logic                   phase_link_i,     // Phase link pin level
    output logic                        phase_link_o,     // Phase link drive value
    output logic                        phase_link_oe,    // Phase link drive enable
    output logic                        ok_flag_o,        // Ok flag drive value
    output logic                        ok_flag_oe,       // Ok flag pull-down enable
    output logic                        high_side_gate_drive, // High-side drive
    input  wire logic [psg_pkg::AW-1:0] reg_addr,         // Register address
    input  wire logic [psg_pkg::DW-1:0] reg_wdata,        // Write data
    input  wire logic                   reg_wr,           // Write strobe
    input  wire logic                   reg_rd,           // Read strobe
    output logic      [psg_pkg::DW-1:0] reg_rdata,        // Read data, cycle after strobe
    output logic                        irq               // Level interrupt
);

    import psg_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic psg_role_t role_of(input logic sup, input logic gnd);
        if (sup) begin
            return ROLE_MASTER;
        end else if (gnd) begin
            return ROLE_SLV180;
        end
        return ROLE_SLV0;
    endfunction

    // Period of the 0.7x fallback rate
    function automatic logic [15:0] slow_per(input logic [15:0] per);
        logic [31:0] p;
        p = ({16'h0000, per} * 32'h0000000A) / 32'h00000007;
        return p[15:0];
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [8:0] pin_s;

    psg_sync #(
        .W (9)
    ) u_sync (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .d       ({phase_link_i, role_at_ground, role_at_supply, otp_fault,
                   scp_fault, ocp_fault, uvlo_active, ramp_done, fb_in_window}),
        .q       (pin_s)
    );

    logic fb_s;
    logic ramp_s;
    logic uvlo_s;
    logic ocp_s;
    logic scp_s;
    logic otp_s;
    logic link_s;

    assign fb_s   = pin_s[0];
    assign ramp_s = pin_s[1];
    assign uvlo_s = pin_s[2];
    assign ocp_s  = pin_s[3];
    assign scp_s  = pin_s[4];
    assign otp_s  = pin_s[5];
    assign link_s = pin_s[8];

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    psg_state_t     q;
    psg_state_t     d;
    logic           blk;
    logic           qual;
    logic           edge_r;
    logic           edge_f;
    logic [15:0]    per_eff;
    logic [15:0]    lost_lim;
    logic [NEV-1:0] ev;
    logic [NEV-1:0] clr;

    always_comb begin
        d = q;
        ev = '0;
        clr = '0;
        d.role = role_of(pin_s[6], pin_s[7]);
        // Any of these keeps the flag low
        blk = !fb_s || !ramp_s || uvlo_s || ocp_s || scp_s || otp_s; // [R1] [R2] [R3] [R4] [R5] [R6]

        edge_r = link_s && !q.link_prev;
        edge_f = !link_s && q.link_prev;
        d.link_prev = link_s;
        case (q.role)
            ROLE_SLV180: begin
                qual = edge_r; // [R11]
            end
            ROLE_SLV0: begin
                qual = edge_f; // [R12]
            end
            default: begin
                qual = 1'b0;
            end
        endcase

        // Tolerates the slowest legal input clock before declaring loss
        lost_lim = q.per + (q.per >> 1); // [R17]
        per_eff = (q.lock == LK_TRANSIT) ? slow_per(q.per) : q.per; // [R14]

        // Limitation: a slave clock slower than the free period gives one extra pulse
        // Free-running period counter; a qualifying edge restarts it
        d.cnt = (q.cnt >= per_eff - 16'h0001) ? 16'h0000 : q.cnt + 16'h0001;
        if (qual) begin
            d.cnt = 16'h0000; // [R11] [R12]
        end
        d.wdog = qual ? 16'h0000 :
                 (q.wdog == 16'hFFFF) ? q.wdog : q.wdog + 16'h0001;

        // Clock lock tracking
        if (q.role == ROLE_MASTER) begin
            d.lock = LK_FREE; // [R8]
        end else begin
            case (q.lock)
                LK_FREE: begin
                    if (qual) begin
                        d.lock = LK_LOCKED; // [R17]
                        ev[EV_LOCK] = 1'b1;
                    end
                end
                LK_LOCKED: begin
                    if (!qual && q.wdog >= lost_lim) begin
                        d.lock = LK_TRANSIT; // [R14] [R17]
                        d.tcnt = 16'h0000;
                        ev[EV_LOST] = 1'b1;
                    end
                end
                LK_TRANSIT: begin
                    if (qual) begin
                        d.lock = LK_LOCKED; // [R17]
                        ev[EV_LOCK] = 1'b1;
                    end else if (q.tcnt >= 16'(TRANS_CYC - 1)) begin
                        d.lock = LK_FREE; // [R15]
                    end else begin
                        d.tcnt = q.tcnt + 16'h0001; // [R14]
                    end
                end
                default: begin
                    d.lock = LK_FREE;
                end
            endcase
        end

        // High-side pulse opens at counter zero, where the link clock falls in master and in-phase slave roles
        d.hs = (d.cnt < q.duty);
        d.ph_oe = (d.role == ROLE_MASTER); // [R8]
        d.ph_o = d.ph_oe && (d.cnt >= (per_eff >> 1)); // [R9] [R10]

        // Power-good release delay
        if (blk) begin
            d.pg_cnt = 16'h0000;
        end else if (q.pg_cnt != 16'(OK_CYC)) begin
            d.pg_cnt = q.pg_cnt + 16'h0001; // [R7]
        end
        d.ok_oe = (d.pg_cnt != 16'(OK_CYC)); // [R1] [R7]
        d.ok_lvl = 1'b0;
        ev[EV_OK_UP] = q.ok_oe && !d.ok_oe;
        ev[EV_OK_DN] = !q.ok_oe && d.ok_oe;

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                ADDR_PERIOD: begin
                    d.per = reg_wdata[15:0];
                end
                ADDR_DUTY: begin
                    d.duty = reg_wdata[15:0];
                end
                ADDR_STATUS: begin
                    clr = reg_wdata[NEV-1:0];
                end
                ADDR_MASK: begin
                    d.msk = reg_wdata[NEV-1:0];
                end
                default: begin
                end
            endcase
        end
        // A new event beats a simultaneous clear
        d.sts = (q.sts & ~clr) | ev;
        d.irq = |(d.sts & d.msk);

        // Read data stand only in the cycle after the strobe
        d.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_PERIOD: begin
                    d.rdata = {16'h0000, q.per};
                end
                ADDR_DUTY: begin
                    d.rdata = {16'h0000, q.duty};
                end
                ADDR_STATUS: begin
                    d.rdata = {28'h0000000, q.sts};
                end
                ADDR_MASK: begin
                    d.rdata = {28'h0000000, q.msk};
                end
                ADDR_STATE: begin
                    d.rdata = {21'h000000, !q.ok_oe, q.lock, q.role,
                               otp_s, scp_s, ocp_s, uvlo_s, ramp_s, fb_s};
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            q <= '{role: ROLE_SLV0, lock: LK_FREE, cnt: 16'h0000, wdog: 16'hFFFF,
                   tcnt: 16'h0000, pg_cnt: 16'h0000, link_prev: 1'b0, hs: 1'b0,
                   ph_o: 1'b0, ph_oe: 1'b0, ok_oe: 1'b1, ok_lvl: 1'b0,
                   per: PERIOD_RST, duty: DUTY_RST, sts: '0, msk: '0,
                   rdata: '0, irq: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign phase_link_o         = q.ph_o;
    assign phase_link_oe        = q.ph_oe;
    assign ok_flag_o            = q.ok_lvl;
    assign ok_flag_oe           = q.ok_oe;
    assign high_side_gate_drive = q.hs;
    assign reg_rdata            = q.rdata;
    assign irq                  = q.irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Counts unblocked cycles on its own, so the release delay is checked independently
    logic [15:0] clr_run_q;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            clr_run_q <= 16'h0000;
        end else if (blk) begin
            clr_run_q <= 16'h0000;
        end else if (clr_run_q != 16'hFFFF) begin
            clr_run_q <= clr_run_q + 16'h0001;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_pg_any_block:   assert property (blk |=> ok_flag_oe && !ok_flag_o) // [R1]
        else $error("ok flag released while blocked");
    a_pg_open_drain:  assert property (!ok_flag_oe |-> !ok_flag_o && !$past(blk)) // [R1]
        else $error("ok flag released without a clear cycle");
    a_pg_fb_window:   assert property (!fb_s |=> ok_flag_oe) // [R2]
        else $error("ok flag released with feedback out of window");
    a_pg_ramp_run:    assert property (!ramp_s |-> ##1 ok_flag_oe) // [R3]
        else $error("ok flag released during soft-start");
    a_pg_uvlo_low:    assert property (uvlo_s |=> ok_flag_oe) // [R4]
        else $error("ok flag released under lockout");
    a_pg_fault_low:   assert property ((ocp_s || scp_s) |=> ok_flag_oe) // [R5]
        else $error("ok flag released during current fault");
    a_pg_temp_low:    assert property (otp_s |=> ok_flag_oe) // [R6]
        else $error("ok flag released during overtemperature");
    a_pg_release_time: assert property ($fell(ok_flag_oe) |-> clr_run_q == 16'(OK_CYC)) // [R7]
        else $error("ok flag released at wrong delay");
    a_ms_drive_on:    assert property (q.role == ROLE_MASTER |-> phase_link_oe) // [R8]
        else $error("master not driving phase link");
    // Entry into master may raise the clock mid-period; only steady master is checked
    a_ms_half_duty:   assert property ((q.role == ROLE_MASTER) && $past(phase_link_oe)
                                       && $rose(phase_link_o)
                                       |-> q.cnt == (q.per >> 1)) // [R9]
        else $error("master clock not at half period");
    a_ms_edge_align:  assert property ($past(phase_link_oe) && q.role == ROLE_MASTER
                                       && $rose(high_side_gate_drive) && q.cnt == 16'h0000
                                       |-> $fell(phase_link_o)) // [R10]
        else $error("master clock fall not aligned to high-side rise");
    a_sl_rise_start:  assert property (q.role == ROLE_SLV180 && edge_r && q.duty != 16'h0000
                                       |=> high_side_gate_drive && q.cnt == 16'h0000) // [R11]
        else $error("antiphase slave not started on rising edge");
    a_sl_fall_start:  assert property (q.role == ROLE_SLV0 && edge_f && q.duty != 16'h0000
                                       |=> high_side_gate_drive && q.cnt == 16'h0000) // [R12]
        else $error("in-phase slave not started on falling edge");
    a_lk_transit_len: assert property (q.lock == LK_TRANSIT |-> q.tcnt < 16'(TRANS_CYC)) // [R14]
        else $error("transition interval overran");
    a_lk_back_free:   assert property (q.lock == LK_TRANSIT && !qual
                                       && q.tcnt == 16'(TRANS_CYC - 1)
                                       |=> q.lock == LK_FREE) // [R15]
        else $error("no return to free-running rate");
    a_lk_loss_seen:   assert property (q.role != ROLE_MASTER && q.lock == LK_LOCKED
                                       && !qual && q.wdog >= lost_lim
                                       |=> q.lock == LK_TRANSIT && q.sts[EV_LOST]) // [R17]
        else $error("clock loss not detected");

    c_ok_release:  cover property ($fell(ok_flag_oe));
    c_master_run:  cover property (q.role == ROLE_MASTER ##1 $fell(phase_link_o));
    c_clock_lost:  cover property (q.lock == LK_LOCKED ##1 q.lock == LK_TRANSIT);
    c_relock:      cover property (q.lock == LK_TRANSIT ##1 q.lock == LK_LOCKED);
    c_first_lock:  cover property (q.lock == LK_FREE ##1 q.lock == LK_LOCKED);

    a_lk_relock:      assert property (q.role != ROLE_MASTER && q.lock != LK_LOCKED && qual
                                       |=> q.lock == LK_LOCKED) // [R17]
        else $error("qualifying edge did not relock");

endmodule

// >>> psg_link_src.sv
// Partner model: external synchronisation clock source on the phase link
`timescale 1ns/10ps
module psg_link_src #(
    parameter real HALF_NS = 80.0 // Half period of the 160 ns link clock
) (
    input  wire logic run,        // Clock toggles while high
    output logic      link_clk    // Level driven onto the phase link
);
    // ------------------------------------------------------------
    // Clock source
    // ------------------------------------------------------------
    // Offset start keeps link edges away from the system clock edges.
    // The line holds its level when stopped: a lost clock is a still line.
    initial begin
        link_clk = 1'b0;
        #3.3;
        forever begin
            if (run) begin
                #HALF_NS link_clk = ~link_clk;
            end else begin
                #1;
            end
        end
    end
endmodule

// >>> tb_pwm_sync_and_power_good.sv
// Self-checking bench of the PWM sync and power-good block
`timescale 1ns/10ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin num_errors++; \
    $display("Error %s exp %0h got %0h", nm, e, s); end end
module tb_pwm_sync_and_power_good;
    import psg_pkg::*;
    typedef struct { string n; logic [DW-1:0] e; logic [DW-1:0] m; } psg_note_t;
    localparam logic [5:0] GOOD = 6'h30;
    logic            clk_sys = 1'b0;
    logic            rst_b, fb_in_window, ramp_done, uvlo_active, ocp_fault, scp_fault;
    logic            otp_fault, role_at_supply, role_at_ground, reg_wr, reg_rd, link_run;
    logic [AW-1:0]   reg_addr;
    logic [DW-1:0]   reg_wdata, reg_rdata;
    logic            phase_link_o, phase_link_oe, ok_flag_o, ok_flag_oe, hs, irq, src_clk;
    logic            hs_s, lk_s, ph_s, rd_d, fall_on_rise;
    wire             link_pin = phase_link_oe ? phase_link_o : src_clk;
    wire             ok_pin   = ok_flag_oe ? ok_flag_o : 1'b1;
    int              cyc, num_errors, n_tests, seed, hs_rise, hs_gap, ph_hi, ph_hi_last;
    int              lk_rise, lk_fall, dly_r, dly_f;
    psg_note_t       q[$];

    always #5 clk_sys = ~clk_sys;

    psg_link_src u_src (.run(link_run), .link_clk(src_clk));

    psg_top uut (
        .clk_sys(clk_sys), .rst_b(rst_b), .fb_in_window(fb_in_window),
        .ramp_done(ramp_done), .uvlo_active(uvlo_active), .ocp_fault(ocp_fault),
        .scp_fault(scp_fault), .otp_fault(otp_fault), .role_at_supply(role_at_supply),
        .role_at_ground(role_at_ground), .phase_link_i(link_pin),
        .phase_link_o(phase_link_o), .phase_link_oe(phase_link_oe),
        .ok_flag_o(ok_flag_o), .ok_flag_oe(ok_flag_oe), .high_side_gate_drive(hs),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq)
    );

    // ------------------------------------------------------------
    // Bus tasks: one strobe cycle, then a quiet cycle before the next
    // ------------------------------------------------------------
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e,
                      input logic [DW-1:0] m, input string n);
        q.push_back('{n, e, m});
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic pg_release(input int lo, input int hi);
        int c;
        c = 0;
        while (ok_flag_oe !== 1'b0 && c < 2100) begin
            @(posedge clk_sys);
            c++;
        end
        `CHK("release cycles", 1'b1, (c >= lo && c <= hi))
        `CHK("ok pin high", 1'b1, ok_pin)
    endtask

    task automatic finish_test();
        $display("Checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Monitor: edge timing and read data against the oldest note
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        psg_note_t x;
        cyc  <= cyc + 1;
        hs_s <= hs;
        lk_s <= link_pin;
        ph_s <= phase_link_o;
        rd_d <= reg_rd;
        ph_hi <= (phase_link_o === 1'b1) ? ph_hi + 1 : 0;
        if (hs === 1'b1 && hs_s === 1'b0) begin
            hs_rise <= cyc;
            hs_gap  <= cyc - hs_rise;
            dly_r   <= cyc - lk_rise;
            dly_f   <= cyc - lk_fall;
        end
        if (link_pin && !lk_s) lk_rise <= cyc;
        if (!link_pin && lk_s) lk_fall <= cyc;
        if (phase_link_o === 1'b0 && ph_s === 1'b1) begin
            ph_hi_last   <= ph_hi;
            fall_on_rise <= hs & ~hs_s;
        end
        if (rd_d === 1'b1) begin
            x = q.pop_front();
            `CHK(x.n, x.e, reg_rdata & x.m)
        end
        if (cyc > 40000) begin
            num_errors++;
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 68113;
        cyc = 0;
        {fb_in_window, ramp_done, uvlo_active, ocp_fault, scp_fault, otp_fault} = GOOD;
        {role_at_supply, role_at_ground, reg_wr, reg_rd, link_run, rst_b} = 6'h00;
        reg_addr  = '0;
        reg_wdata = '0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        rd(ADDR_PERIOD, 32'h0000014D, 32'hFFFFFFFF, "period reset");
        rd(ADDR_DUTY, 32'h000000A6, 32'hFFFFFFFF, "duty reset");
        rd(ADDR_MASK, 32'h0, 32'hFFFFFFFF, "mask reset");
        rd(8'h20, 32'h0, 32'hFFFFFFFF, "unmapped read");
        wr(8'h24, $random(seed));
        pg_release(1900, 2010);
        rd(ADDR_STATE, 32'h480, 32'h7C0, "state");
        wr(ADDR_STATUS, 32'hF);
        wr(ADDR_MASK, 32'h2);
        // Each blocking condition in turn, then a timed release
        for (int i = 0; i < 6; i++) begin
            {fb_in_window, ramp_done, uvlo_active, ocp_fault, scp_fault, otp_fault}
                <= GOOD ^ (6'h20 >> i);
            repeat (4) @(posedge clk_sys);
            `CHK("ok oe", 1'b1, ok_flag_oe)
            `CHK("ok pin low", 1'b0, ok_pin)
            `CHK("irq set", 1'b1, irq)
            wr(ADDR_STATUS, 32'h2);
            `CHK("irq clear", 1'b0, irq)
            repeat ($random(seed) & 7) @(posedge clk_sys);
            {fb_in_window, ramp_done, uvlo_active, ocp_fault, scp_fault, otp_fault} <= GOOD;
            pg_release(2000, 2006);
        end
        wr(ADDR_MASK, 32'h0);
        // Master role with a short period
        wr(ADDR_PERIOD, 32'h10);
        wr(ADDR_DUTY, 32'h8);
        role_at_supply <= 1'b1;
        repeat (60) @(posedge clk_sys);
        `CHK("link drive", 1'b1, phase_link_oe)
        `CHK("master period", 16, hs_gap)
        `CHK("link high", 8, ph_hi_last)
        `CHK("fall on rise", 1'b1, fall_on_rise)
        // Antiphase slave locked to the partner clock
        role_at_supply <= 1'b0;
        role_at_ground <= 1'b1;
        link_run       <= 1'b1;
        repeat (100) @(posedge clk_sys);
        `CHK("link released", 1'b0, phase_link_oe)
        `CHK("slave period", 16, hs_gap)
        `CHK("rise delay", 1'b1, (dly_r >= 1 && dly_r <= 5))
        // Clock loss, slowed transition, then free running
        wr(ADDR_STATUS, 32'hF);
        link_run <= 1'b0;
        repeat (80) @(posedge clk_sys);
        `CHK("transit period", 22, hs_gap)
        rd(ADDR_STATUS, 32'h4, 32'h4, "lost flag");
        repeat (2100) @(posedge clk_sys);
        `CHK("free period", 16, hs_gap)
        link_run <= 1'b1;
        repeat (60) @(posedge clk_sys);
        rd(ADDR_STATUS, 32'h8, 32'h8, "lock flag");
        // In-phase slave
        role_at_ground <= 1'b0;
        repeat (100) @(posedge clk_sys);
        `CHK("fall delay", 1'b1, (dly_f >= 1 && dly_f <= 5))
        `CHK("slave0 period", 16, hs_gap)
        finish_test();
    end
endmodule
